//--- pkg/hpp_pkg.sv
// constants and carriers for the host port pin block
// assumes one 25 MHz core clock and port B pins 5..15
package hpp_pkg;

  // ==========================================
  // pin map: vector index 0 is port B pin 5
  localparam int PIN_COUNT = 11;
  localparam int IDX_DATA  = 0;
  localparam int IDX_ADDR  = 3;
  localparam int IDX_DIR   = 6;
  localparam int IDX_XFER  = 7;
  localparam int IDX_SEL   = 8;
  localparam int IDX_REQ   = 9;
  localparam int IDX_ACK   = 10;

  // ==========================================
  // modes
  localparam logic STYLE_SINGLE = 1'b0;
  localparam logic STYLE_DOUBLE = 1'b1;
  localparam logic RMODE_SHARED = 1'b0;
  localparam logic RMODE_SPLIT  = 1'b1;

  // ==========================================
  // reset values
  localparam logic [10:0] PIN_OE_RST  = 11'h000;
  localparam logic [10:0] PIN_OUT_RST = 11'h7ff;
  localparam logic        PIN_IDLE    = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } hpp_state_t;

  // sampled host pins, strobes active low
  typedef struct packed {
    logic       dir;
    logic       xfer_n;
    logic       sel_n;
    logic [2:0] addr;
    logic [2:0] data;
  } hpp_pins_t;

  localparam hpp_pins_t PINS_RST = '{
    dir: 1'b1, xfer_n: 1'b1, sel_n: 1'b1,
    addr: 3'h0, data: 3'h0};

  // one register access toward the register bank
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [2:0] data;
  } hpp_access_t;

  localparam hpp_access_t ACC_RST = '{
    rd: 1'b0, wr: 1'b0, addr: 3'h0, data: 3'h0};

endpackage : hpp_pkg

//--- verilog/hpp_pin_cell.sv
// one shared pin: host function or port B general purpose
// assumes caller gates enable and reset
`timescale 1ns/10ps
module hpp_pin_cell #(
  parameter logic OUT_RST = 1'b1
) (
  // clock and control
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic en_in,
  // selection
  input  wire logic host_mode_in,
  input  wire logic host_pull_in,
  // general purpose side
  input  wire logic gpio_out_in,
  input  wire logic gpio_oe_in,
  // pad
  output logic      pin_out,
  output logic      pin_oe_out
);

  // host side only ever pulls low (open drain)
  wire logic next_oe  = host_mode_in ? host_pull_in : gpio_oe_in;
  wire logic next_out = host_mode_in ? 1'b0 : gpio_out_in;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pin_oe_out <= 1'b0;
      pin_out    <= OUT_RST;
    end
    else if (en_in)
    begin
      pin_oe_out <= next_oe;
      pin_out    <= next_out;
    end
  end

endmodule : hpp_pin_cell

//--- verilog/hpp_edge_det.sv
// assertion edge of a sampled active level
// assumes level is already synchronous
`timescale 1ns/10ps
module hpp_edge_det (
  // clock and control
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic en_in,
  // level in, edge out
  input  wire logic level_in,
  output logic      rise_out
);

  logic prev;

  assign rise_out = level_in & ~prev;

  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      prev <= 1'b0;
    else if (en_in)
      prev <= level_in;
  end

endmodule : hpp_edge_det

//--- verilog/hpp_host_port.sv
// host port pin logic: strobes, addressing, requests
// assumes pins synchronous to core_clk_in, pads resolved outside
`timescale 1ns/10ps

// How it works
// - data lines are inputs, dead during reset
// - three address lines pick the register
// - address lines dead during reset
// - unselected: pins act as port B
// - single strobe: direction input picks read/write
// - double strobe: direction pin strobes reads
// - single strobe: transfer needs chip select
// - double strobe: transfer pin strobes writes
// - mode zero: one open-drain service request
// - mode one: same pin is transmit request
// - mode one: acknowledge pin is receive request
// - mode zero: acknowledge pin is host input
module hpp_host_port (
  // clock, reset, enable
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_in,
  input  wire logic                     clk_en_in,
  // configuration
  input  wire logic                     host_sel_in,
  input  wire logic                     bus_style_in,
  input  wire logic                     request_mode_select_in,
  // request sources
  input  wire logic                     svc_req_in,
  input  wire logic                     tx_req_in,
  input  wire logic                     rx_req_in,
  // port B general purpose side
  input  wire logic [10:0]              gpio_out_in,
  input  wire logic [10:0]              gpio_oe_in,
  output logic [10:0]                   gpio_din_out,
  // pads, port B pins 5..15
  input  wire logic [10:0]              portb_pin_in,
  output logic [10:0]                   portb_pin_out,
  output logic [10:0]                   portb_pin_oe_out,
  // register access and acknowledge
  output hpp_pkg::hpp_access_t          reg_access_out,
  output logic                          host_acknowledge_out
);

  // ==========================================
  // sampled host pins
  hpp_pkg::hpp_pins_t smp;
  hpp_pkg::hpp_pins_t next_smp;
  hpp_pkg::hpp_state_t state;
  hpp_pkg::hpp_state_t next_state;
  hpp_pkg::hpp_access_t next_acc;

  wire logic [2:0] pin_data = portb_pin_in[hpp_pkg::IDX_DATA +: 3];
  wire logic [2:0] pin_addr = portb_pin_in[hpp_pkg::IDX_ADDR +: 3];

  // outside host mode the sample stays idle
  assign next_smp = host_sel_in ? hpp_pkg::hpp_pins_t'{
    dir:    portb_pin_in[hpp_pkg::IDX_DIR],
    xfer_n: portb_pin_in[hpp_pkg::IDX_XFER],
    sel_n:  portb_pin_in[hpp_pkg::IDX_SEL],
    addr:   pin_addr,
    data:   pin_data}
    : hpp_pkg::PINS_RST;

  // reset holds the sample at idle: inputs disconnected
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
      smp <= hpp_pkg::PINS_RST;
    else if (clk_en_in)
      smp <= next_smp;
  end

  // ==========================================
  // strobe decode
  wire logic is_double = (bus_style_in == hpp_pkg::STYLE_DOUBLE);
  wire logic cs_act    = ~smp.sel_n;
  wire logic rd_level  = is_double & ~smp.dir & cs_act;
  wire logic xf_level  = ~smp.xfer_n & cs_act;
  wire logic rise_rd;
  wire logic rise_xf;

  hpp_edge_det u_det_rd (
    .clk_in   (core_clk_in),
    .reset_in (reset_in),
    .en_in    (clk_en_in),
    .level_in (rd_level),
    .rise_out (rise_rd)
  );

  hpp_edge_det u_det_xf (
    .clk_in   (core_clk_in),
    .reset_in (reset_in),
    .en_in    (clk_en_in),
    .level_in (xf_level),
    .rise_out (rise_xf)
  );

  // single strobe: direction input high means read
  wire logic start_rd = is_double ? rise_rd
                                  : rise_xf & smp.dir;
  wire logic start_wr = is_double ? rise_xf
                                  : rise_xf & ~smp.dir;
  wire logic strobes_off = ~rd_level & ~xf_level;

  // ==========================================
  // access sequencer: one access per strobe
  always_comb
  begin
    next_state = state;
    next_acc   = hpp_pkg::ACC_RST;
    case (state)
      hpp_pkg::ST_IDLE:
      begin
        if (start_rd | start_wr)
        begin
          next_state    = hpp_pkg::ST_HOLD;
          next_acc.rd   = start_rd;
          next_acc.wr   = start_wr;
          next_acc.addr = smp.addr;
          next_acc.data = smp.data;
        end
      end
      hpp_pkg::ST_HOLD:
      begin
        // wait for release so a long strobe is one access
        if (strobes_off)
          next_state = hpp_pkg::ST_IDLE;
      end
      default:
        next_state = hpp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state          <= hpp_pkg::ST_IDLE;
      reg_access_out <= hpp_pkg::ACC_RST;
    end
    else if (clk_en_in)
    begin
      state          <= next_state;
      reg_access_out <= next_acc;
    end
  end

  // ==========================================
  // requests and acknowledge
  wire logic split  = (request_mode_select_in == hpp_pkg::RMODE_SPLIT);
  wire logic req_tx = split ? tx_req_in : svc_req_in;
  wire logic req_rx = split & rx_req_in;
  wire logic next_ack = host_sel_in & ~split
                      & ~portb_pin_in[hpp_pkg::IDX_ACK];

  // only the two request pins ever pull in host mode
  wire logic [10:0] host_pull = {req_rx, req_tx, 9'h000};

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      host_acknowledge_out <= 1'b0;
      gpio_din_out         <= 11'h000;
    end
    else if (clk_en_in)
    begin
      host_acknowledge_out <= next_ack;
      gpio_din_out         <= portb_pin_in;
    end
  end

  // ==========================================
  // pad cells
  genvar g;
  generate
    for (g = 0; g < hpp_pkg::PIN_COUNT; g++)
    begin : g_pin
      hpp_pin_cell #(
        .OUT_RST (hpp_pkg::PIN_OUT_RST[g])
      ) u_cell (
        .clk_in       (core_clk_in),
        .reset_in     (reset_in),
        .en_in        (clk_en_in),
        .host_mode_in (host_sel_in),
        .host_pull_in (host_pull[g]),
        .gpio_out_in  (gpio_out_in[g]),
        .gpio_oe_in   (gpio_oe_in[g]),
        .pin_out      (portb_pin_out[g]),
        .pin_oe_out   (portb_pin_oe_out[g])
      );
    end
  endgenerate

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_rd_start;
    clk_en_in && state == hpp_pkg::ST_IDLE && is_double && rise_rd;
  endsequence

  sequence s_wr_start;
    clk_en_in && state == hpp_pkg::ST_IDLE && is_double && rise_xf;
  endsequence

  a_reset_quiet: assert property (
    @(posedge core_clk_in) disable iff (1'b0)
    reset_in |-> !reg_access_out.rd && !reg_access_out.wr
      && portb_pin_oe_out == hpp_pkg::PIN_OE_RST)
    else $error("access or drive during reset");

  a_read_strobe: assert property (
    s_rd_start |=> reg_access_out.rd && !reg_access_out.wr
      && reg_access_out.addr == $past(smp.addr))
    else $error("read strobe gave no read");

  a_write_strobe: assert property (
    s_wr_start |=> reg_access_out.wr && !reg_access_out.rd
      && reg_access_out.data == $past(smp.data))
    else $error("write strobe gave no write");

  a_dir_select: assert property (
    clk_en_in && state == hpp_pkg::ST_IDLE && !is_double && rise_xf
      |=> reg_access_out.rd == $past(smp.dir)
      && reg_access_out.wr == !$past(smp.dir))
    else $error("direction input misread");

  a_select_gate: assert property (
    clk_en_in && smp.sel_n |=> !reg_access_out.rd && !reg_access_out.wr)
    else $error("access without chip select");

  a_single_pulse: assert property (
    clk_en_in && (reg_access_out.rd || reg_access_out.wr)
      |=> !reg_access_out.rd && !reg_access_out.wr)
    else $error("access pulse longer than one cycle");

  a_req_shared: assert property (
    clk_en_in && host_sel_in && !split |=>
      portb_pin_oe_out[hpp_pkg::IDX_REQ] == $past(svc_req_in)
      && !portb_pin_out[hpp_pkg::IDX_REQ])
    else $error("service request pin wrong");

  a_req_split: assert property (
    clk_en_in && host_sel_in && split |=>
      portb_pin_oe_out[hpp_pkg::IDX_REQ] == $past(tx_req_in)
      && portb_pin_oe_out[hpp_pkg::IDX_ACK] == $past(rx_req_in))
    else $error("split request pins wrong");

  a_ack_input: assert property (
    clk_en_in && host_sel_in && !split |=>
      !portb_pin_oe_out[hpp_pkg::IDX_ACK]
      && host_acknowledge_out == !$past(portb_pin_in[hpp_pkg::IDX_ACK]))
    else $error("acknowledge input wrong");

  a_gpio_fallback: assert property (
    clk_en_in && !host_sel_in |=>
      portb_pin_oe_out == $past(gpio_oe_in)
      && portb_pin_out == $past(gpio_out_in))
    else $error("port B fallback wrong");

  a_inputs_float: assert property (
    clk_en_in && host_sel_in |=> portb_pin_oe_out[8:0] == 9'h000)
    else $error("host input pin driven");

endmodule : hpp_host_port

//--- verif/hpp_host_model.sv
// host-side pad model for the host port pin block
// assumes the bench supplies host pin levels, strobes active low
`timescale 1ns/10ps
module hpp_host_model (
  // mode
  input  wire logic        host_mode_in,
  input  wire logic        split_mode_in,
  // host side levels
  input  wire logic [10:0] host_drive_in,
  // device pad drive
  input  wire logic [10:0] dev_out_in,
  input  wire logic [10:0] dev_oe_in,
  // resolved pads
  output logic [10:0]      pad_out
);
  // ==========================================
  // pad resolution
  logic [10:0] host_level;
  logic        ack_level;

  // request pins only carry the pull-up in host mode; a released pin never keeps a stale value
  assign ack_level  = split_mode_in ? 1'b1 : host_drive_in[10];
  assign host_level = host_mode_in
                      ? {ack_level, 1'b1, host_drive_in[8:0]}
                      : host_drive_in;
  assign pad_out    = (dev_oe_in & dev_out_in) | (~dev_oe_in & host_level);
endmodule : hpp_host_model

//--- verif/hpp_host_port_test.sv
// self-checking bench for the host port pin block
// assumes a 25 MHz core clock and the pad model beside the design
`timescale 1ns/10ps
module hpp_host_port_test;
  // ==========================================
  // stimulus and observation
  localparam logic [10:0] IDLE = 11'h7ff;
  logic                 core_clk_in = 1'b0;
  logic                 reset_in    = 1'b0;
  logic                 clk_en      = 1'b1;
  logic                 host_sel    = 1'b1;
  logic                 style       = 1'b0;
  logic                 rmode       = 1'b0;
  logic                 svc         = 1'b0;
  logic                 tx          = 1'b0;
  logic                 rx          = 1'b0;
  logic [10:0]          gpio_out    = 11'h000;
  logic [10:0]          gpio_oe     = 11'h000;
  logic [10:0]          host_drv    = IDLE;
  logic [10:0]          pad;
  logic [10:0]          gpio_din;
  logic [10:0]          pin_out;
  logic [10:0]          pin_oe;
  hpp_pkg::hpp_access_t acc;
  logic                 ack;
  int                   failures    = 0;
  int                   checks_done = 0;
  int                   cycles      = 0;

  always #20 core_clk_in = ~core_clk_in;

  hpp_host_port hpp_host_port_i (
    .core_clk_in           (core_clk_in),
    .reset_in              (reset_in),
    .clk_en_in             (clk_en),
    .host_sel_in           (host_sel),
    .bus_style_in          (style),
    .request_mode_select_in(rmode),
    .svc_req_in            (svc),
    .tx_req_in             (tx),
    .rx_req_in             (rx),
    .gpio_out_in           (gpio_out),
    .gpio_oe_in            (gpio_oe),
    .gpio_din_out          (gpio_din),
    .portb_pin_in          (pad),
    .portb_pin_out         (pin_out),
    .portb_pin_oe_out      (pin_oe),
    .reg_access_out        (acc),
    .host_acknowledge_out  (ack)
  );

  hpp_host_model hpp_host_model_i (
    .host_mode_in (host_sel),
    .split_mode_in(rmode),
    .host_drive_in(host_drv),
    .dev_out_in   (pin_out),
    .dev_oe_in    (pin_oe),
    .pad_out      (pad)
  );

  // ==========================================
  // shared tasks
  task automatic check(input logic [10:0] seen, input logic [10:0] expected);
    checks_done++;
    if (seen !== expected)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // one host access; expect_hit low means the port must stay silent
  task automatic do_access(input logic st, input logic rd, input logic [2:0] addr,
                           input logic [2:0] data, input logic cs_n, input logic expect_hit);
    hpp_pkg::hpp_access_t exp;
    logic                 dir;
    logic                 xfer_n;
    exp    = hpp_pkg::ACC_RST;
    dir    = (st == hpp_pkg::STYLE_SINGLE) ? rd : !rd;
    xfer_n = (st == hpp_pkg::STYLE_SINGLE) ? 1'b0 : rd;
    if (expect_hit)
    begin
      exp.rd   = rd;
      exp.wr   = !rd;
      exp.addr = addr;
      exp.data = data;
    end
    @(posedge core_clk_in);
    style    <= st;
    host_drv <= {2'b11, cs_n, xfer_n, dir, addr, data};
    repeat (2) @(posedge core_clk_in);
    #1 check(11'(acc), 11'(exp));
    @(posedge core_clk_in);
    #1 check(11'(acc), 11'(hpp_pkg::ACC_RST));
    @(posedge core_clk_in);
    host_drv <= IDLE;
    repeat (2) @(posedge core_clk_in);
  endtask : do_access

  // ==========================================
  // scenarios
  task automatic test_reset();
    // a full access held during reset must leave no trace
    // reset rises at time zero so the flops see a real edge
    reset_in <= 1'b1;
    host_drv <= 11'h63d;
    repeat (15)
    begin
      @(posedge core_clk_in);
      #1 check(pin_oe, hpp_pkg::PIN_OE_RST);
      check(11'(acc), 11'(hpp_pkg::ACC_RST));
    end
    @(posedge core_clk_in);
    host_drv <= IDLE;
    reset_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1 check(11'(acc), 11'(hpp_pkg::ACC_RST));
  endtask : test_reset

  task automatic test_accesses();
    for (int s = 0; s < 2; s++)
      for (int r = 0; r < 2; r++)
        do_access(s[0], r[0], 3'(s * 4 + r * 3), r[0] ? 3'h0 : 3'(~(s * 4)), 1'b0, 1'b1);
    do_access(hpp_pkg::STYLE_SINGLE, 1'b0, 3'h5, 3'h2, 1'b1, 1'b0);
    do_access(hpp_pkg::STYLE_DOUBLE, 1'b1, 3'h6, 3'h0, 1'b1, 1'b0);
  endtask : test_accesses

  task automatic test_gpio();
    @(posedge core_clk_in);
    host_sel <= 1'b0;
    gpio_oe  <= 11'h7ff;
    gpio_out <= 11'h5a5;
    repeat (2) @(posedge core_clk_in);
    #1 check(pin_oe, 11'h7ff);
    check(pad, 11'h5a5);
    do_access(hpp_pkg::STYLE_SINGLE, 1'b0, 3'h3, 3'h4, 1'b0, 1'b0);
    @(posedge core_clk_in);
    gpio_oe  <= 11'h000;
    host_drv <= 11'h2b3;
    repeat (3) @(posedge core_clk_in);
    #1 check(gpio_din, 11'h2b3);
    check(11'(acc), 11'(hpp_pkg::ACC_RST));
    @(posedge core_clk_in);
    host_drv <= IDLE;
    host_sel <= 1'b1;
    repeat (2) @(posedge core_clk_in);
  endtask : test_gpio

  task automatic test_requests();
    logic [2:0] req_tab [4];
    logic [10:0] oe_tab [4];
    req_tab = '{3'b100, 3'b010, 3'b001, 3'b011};
    oe_tab  = '{11'h200, 11'h200, 11'h400, 11'h600};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk_in);
      rmode <= (i != 0);
      {svc, tx, rx} <= req_tab[i];
      repeat (2) @(posedge core_clk_in);
      #1 check(pin_oe, oe_tab[i]);
      check(11'(pad[10:9] & oe_tab[i][10:9]), 11'h000);
      @(posedge core_clk_in);
      {svc, tx, rx} <= 3'b000;
      repeat (2) @(posedge core_clk_in);
      #1 check(pin_oe, 11'h000);
      check(11'(pad[10:9]), 11'h003);
    end
  endtask : test_requests

  task automatic test_ack();
    @(posedge core_clk_in);
    rmode    <= hpp_pkg::RMODE_SHARED;
    host_drv <= 11'h3ff;
    repeat (2) @(posedge core_clk_in);
    #1 check(11'(ack), 11'h001);
    check(pin_oe, 11'h000);
    @(posedge core_clk_in);
    host_drv <= IDLE;
    repeat (2) @(posedge core_clk_in);
    #1 check(11'(ack), 11'h000);
  endtask : test_ack

  task automatic test_freeze();
    // enable low must hold every flop, a pending request included
    @(posedge core_clk_in);
    rmode  <= hpp_pkg::RMODE_SHARED;
    clk_en <= 1'b0;
    svc    <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1 check(pin_oe, 11'h000);
    @(posedge core_clk_in);
    clk_en <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1 check(pin_oe, 11'h200);
    @(posedge core_clk_in);
    svc <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask : test_freeze

  // ==========================================
  // hang guard and main sequence
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      give_verdict();
    end
  end

  initial
  begin
    test_reset();
    test_accesses();
    test_gpio();
    test_requests();
    test_ack();
    test_freeze();
    give_verdict();
  end
endmodule : hpp_host_port_test
